// >>> rtl/uart9_defines.vh
// register map, field positions and divider counts for the nine-bit uart
`ifndef UART9_DEFINES_VH
`define UART9_DEFINES_VH
`define ADDR_DATA 8'hd6
`define ADDR_CTRL 8'hd7
`define BIT_RX_READY_FLAG 7
`define BIT_TX_EMPTY_FLAG 6
`define BIT_RX_IRQ_ENABLE 5
`define BIT_TX_IRQ_ENABLE 4
`define BIT_BAUD_HI 3
`define BIT_BAUD_LO 1
`define BIT_NINTH 0
`define CTRL_RESET 8'h00
`define DIV_SEL0 16'd6656
`define DIV_SEL1 16'd3328
`define DIV_SEL2 16'd1664
`define DIV_SEL3 16'd832
`define DIV_SEL4 16'd416
`define DIV_SEL5 16'd256
`define DIV_SEL6 16'd208
`define OVERSAMPLE 4'd8
`define CHAR_BITS 4'd11
`endif

// >>> rtl/half_duplex_nine_bit_uart.v
// half-duplex nine-bit uart with 8x oversampled receiver and register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "uart9_defines.vh"

module half_duplex_nine_bit_uart #(
    parameter DIV_W = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    // serial pins
    input wire rx_in,
    input wire port_level,
    output reg tx_out,
    output reg tx_output_select,
    // interrupt request to the core
    output reg irq
);

    // state codes, one-hot
    localparam RX_IDLE = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_DATA = 3'b100;
    // RX_IDLE waits for a falling edge, RX_START skips the start bit,
    // RX_DATA takes nine data bits and then sits out the stop bit

    // control register fields
    reg rx_ready_flag_q;
    reg tx_empty_flag_q;
    reg rx_irq_enable_q;
    reg tx_irq_enable_q;
    reg [2:0] baud_select_q;
    reg ninth_bit_q;
    // receive buffer
    reg [7:0] rx_buf_q;
    // divider and tick
    reg [DIV_W-1:0] div_cnt_q;
    // one-cycle enable at eight times the baud rate
    reg tick_q;
    // transmitter
    reg tx_busy_q;
    // stop, ninth and eight data bits, shifted toward bit 0
    reg [9:0] tx_shift_q;
    reg [3:0] tx_bit_q;
    reg [2:0] tx_phase_q;
    // receiver
    reg [2:0] rx_state_q;
    reg [2:0] rx_phase_q;
    reg [3:0] rx_bit_q;
    reg [8:0] rx_shift_q;
    // last three samples for the majority vote
    reg [2:0] rx_votes_q;
    // previous pin level for the edge test
    reg rx_prev_q;

    // the register port never stalls: writes act on the strobe edge and reads
    // answer one cycle later, so no handshake state is needed here
    // register decodes
    wire wr_data = wr_en && (addr == `ADDR_DATA);
    wire wr_ctrl = wr_en && (addr == `ADDR_CTRL);

    // divisor table, counted in ref_clk cycles per bit; the 8x tick below
    // divides by one eighth of it, so every entry must be a multiple of eight
    // divisor per baud code; reserved code reuses the slowest, a safe harmless pick
    function [DIV_W-1:0] divisor;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: divisor = `DIV_SEL0;
                3'h1: divisor = `DIV_SEL1;
                3'h2: divisor = `DIV_SEL2;
                3'h3: divisor = `DIV_SEL3;
                3'h4: divisor = `DIV_SEL4;
                3'h5: divisor = `DIV_SEL5;
                3'h6: divisor = `DIV_SEL6;
                default: divisor = `DIV_SEL0;
            endcase
        end
    endfunction

    // one eighth of the divisor gives the 8x tick
    // the shift is exact since every divisor is a multiple of eight
    wire [DIV_W-1:0] tick_div = divisor(baud_select_q) >> 3;

    // two-of-three vote
    // a single glitch inside the window cannot flip the decided bit
    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // limitation: the first tick after a data write or a start edge comes
    // anywhere from one to tick_div cycles later, because the counter runs free;
    // the start bit therefore jitters by up to one tick, well inside the vote window
    // 8x oversampling tick; compare with live select so a change acts at once
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            div_cnt_q <= {DIV_W{1'b0}};
            tick_q <= 1'b0;
        end else if (div_cnt_q >= tick_div - 1'b1) begin
            // >= rather than == so a smaller divisor written mid-count acts at once
            div_cnt_q <= {DIV_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // tx_bit_q counts bit periods: 0 is the start bit, 1..8 the data bits,
    // 9 the ninth bit and 10 the stop bit; tx_phase_q counts ticks inside a bit
    // the shifter moves only from bit 2 on, so bit 1 shows wdata[0] unshifted
    // transmitter: ten bits shifted after the start bit, one bit per eight ticks
    wire tx_done = tx_busy_q && tick_q && (tx_phase_q == 3'd7) && (tx_bit_q == `CHAR_BITS - 1'b1);
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_busy_q <= 1'b0;
            tx_shift_q <= 10'h3ff;
            tx_bit_q <= 4'h0;
            tx_phase_q <= 3'h0;
        end else if (wr_data) begin
            // a write while busy restarts the character from its start bit
            // stop bit, ninth bit, data lsb first
            tx_busy_q <= 1'b1;
            tx_shift_q <= {1'b1, ninth_bit_q, wdata};
            tx_bit_q <= 4'h0;
            tx_phase_q <= 3'h0;
        end else if (tx_busy_q && tick_q) begin
            // one tick of the current bit has passed
            tx_phase_q <= tx_phase_q + 1'b1;
            if (tx_phase_q == 3'd7) begin
                // last tick of a bit period
                if (tx_done) begin
                    // stop bit complete; hand the pin back to the port
                    tx_busy_q <= 1'b0;
                end else begin
                    // advance to the next bit
                    tx_bit_q <= tx_bit_q + 1'b1;
                    if (tx_bit_q != 4'h0) begin
                        tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                    end
                end
            end
        end
    end

    // registered so that both pins change on the same edge; tx_output_select
    // therefore trails tx_busy_q by one cycle, as does tx_out
    // output mux: transmitter while busy, port value otherwise
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_out <= 1'b1;
            tx_output_select <= 1'b0;
        end else begin
            tx_output_select <= tx_busy_q;
            if (!tx_busy_q) begin
                // idle: the port drives the pin; software keeps it high for a clean stop
                tx_out <= port_level;
            end else if (tx_bit_q == 4'h0) begin
                // start bit
                tx_out <= 1'b0;
            end else begin
                tx_out <= tx_shift_q[0];
            end
        end
    end

    // rx_prev_q resets to the idle high level, so no false start edge follows reset
    // the edge test uses the pin as sampled; pin inputs are taken as synchronous
    // receiver sequence: start skip, then nine data bits plus stop bit period
    wire rx_fall = rx_prev_q && !rx_in;
    wire rx_bit_end = tick_q && (rx_phase_q == 3'd7);
    // rx_finish marks the end of the stop period, after bit index 9
    wire rx_finish = (rx_state_q == RX_DATA) && rx_bit_end && (rx_bit_q == 4'd9);
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_phase_q <= 3'h0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 9'h000;
            rx_votes_q <= 3'h0;
            rx_prev_q <= 1'b1;
            rx_buf_q <= 8'h00;
        end else begin
            rx_prev_q <= rx_in;
            if (tx_busy_q || wr_data) begin
                // transmit owns the shared state; a half-taken character is dropped
                rx_state_q <= RX_IDLE;
                rx_phase_q <= 3'h0;
            end else begin
                case (rx_state_q)
                    RX_IDLE: begin
                        // only the falling edge leaves idle
                        if (rx_fall) begin
                            rx_state_q <= RX_START;
                            rx_phase_q <= 3'h0;
                        end
                    end
                    RX_START: begin
                        // eight ticks cover the start bit; its level is not checked
                        if (tick_q) begin
                            rx_phase_q <= rx_phase_q + 1'b1;
                        end
                        if (rx_bit_end) begin
                            rx_state_q <= RX_DATA;
                            rx_bit_q <= 4'h0;
                        end
                    end
                    RX_DATA: begin
                        // votes from states 3 to 5, decided at state 7 of each bit
                        if (tick_q) begin
                            rx_phase_q <= rx_phase_q + 1'b1;
                            // samples at states 3, 4, 5
                            if (rx_phase_q >= 3'd3 && rx_phase_q <= 3'd5) begin
                                rx_votes_q <= {rx_votes_q[1:0], rx_in};
                            end
                        end
                        if (rx_bit_end) begin
                            // bit 9 is the stop period and is not shifted in
                            if (rx_bit_q < 4'd9) begin
                                rx_shift_q <= {maj3(rx_votes_q), rx_shift_q[8:1]};
                            end
                            rx_bit_q <= rx_bit_q + 1'b1;
                        end
                        if (rx_finish) begin
                            // stop level is not checked; buffer simply overwritten
                            rx_buf_q <= rx_shift_q[7:0];
                            rx_state_q <= RX_IDLE;
                        end
                    end
                    default: begin
                        // unreachable codes fall back to idle
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // rx_load is gated by the same abort terms as the receiver, so a character
    // cut short by a transmission never reaches the buffer or the flags
    // control register; hardware sets win over a software clear in the same cycle
    wire rx_load = rx_finish && !tx_busy_q && !wr_data;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_ready_flag_q <= 1'b0;
            tx_empty_flag_q <= 1'b0;
            rx_irq_enable_q <= 1'b0;
            tx_irq_enable_q <= 1'b0;
            baud_select_q <= 3'h0;
            ninth_bit_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // enables and baud code are plain software fields
                rx_irq_enable_q <= wdata[`BIT_RX_IRQ_ENABLE];
                tx_irq_enable_q <= wdata[`BIT_TX_IRQ_ENABLE];
                baud_select_q <= wdata[`BIT_BAUD_HI:`BIT_BAUD_LO];
            end
            // rx flag: writable both ways, hardware set dominates
            // writing a one is a software interrupt request when rx_irq_enable is on
            if (rx_load) begin
                rx_ready_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                rx_ready_flag_q <= wdata[`BIT_RX_READY_FLAG];
            end
            // tx flag: set at end of character, cleared by data write or zero
            // a data write in the same cycle as tx_done leaves the flag set
            if (tx_done) begin
                tx_empty_flag_q <= 1'b1;
            end else if (wr_data) begin
                tx_empty_flag_q <= 1'b0;
            end else if (wr_ctrl) begin
                tx_empty_flag_q <= wdata[`BIT_TX_EMPTY_FLAG];
            end
            // ninth bit: received value overwrites software value
            // software should set it again before the next transmission
            if (rx_load) begin
                ninth_bit_q <= rx_shift_q[8];
            end else if (wr_ctrl) begin
                ninth_bit_q <= wdata[`BIT_NINTH];
            end
        end
    end

    // reads have no side effects: the flags clear only by explicit writes,
    // so polling the control register never loses an event
    // read data one cycle after strobe; unmapped reads return zero
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en && addr == `ADDR_DATA) begin
            rdata <= rx_buf_q;
        end else if (rd_en && addr == `ADDR_CTRL) begin
            rdata <= {rx_ready_flag_q, tx_empty_flag_q, rx_irq_enable_q,
                      tx_irq_enable_q, baud_select_q, ninth_bit_q};
        end else begin
            rdata <= 8'h00;
        end
    end

    // the request is a level; it stays up until software clears the flag
    // or the enable, and a software-set flag raises it like a hardware one
    // combined interrupt request from the two flag/enable pairs
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (rx_ready_flag_q & rx_irq_enable_q) | (tx_empty_flag_q & tx_irq_enable_q);
        end
    end

endmodule // half_duplex_nine_bit_uart

// >>> tb/uart9_assertions.sv
// port-level assertion checker for the nine-bit uart
`timescale 1ns/1ps
`include "uart9_defines.vh"
module uart9_checker (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata,
    // pins and request
    input wire rx_in,
    input wire port_level,
    input wire tx_out,
    input wire tx_output_select,
    input wire irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire cw = wr_en && addr == `ADDR_CTRL; // control write
    chk_rdata_idle: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data not idle");
    chk_unmapped_read: assert property (
        rd_en && addr != `ADDR_DATA && addr != `ADDR_CTRL |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_tx_start: assert property (
        wr_en && addr == `ADDR_DATA |=> ##1 tx_output_select && !tx_out)
        else $error("data write did not start a character");
    chk_start_low: assert property ($rose(tx_output_select) |-> !tx_out [*8])
        else $error("start bit not low");
    chk_stop_high: assert property (
        $fell(tx_output_select) |-> $past(tx_out, 2) && $past(tx_out, 8))
        else $error("stop bit not high");
    chk_idle_follow: assert property (
        !tx_output_select && !$past(tx_output_select) && !$past(tx_output_select, 2)
        |-> tx_out == $past(port_level)) else $error("idle pin not following port");
    chk_irq_quiet: assert property (cw && wdata[5:4] == 2'b00 ##1 !wr_en |=> !irq)
        else $error("request without enable");
    chk_irq_soft: assert property (cw && wdata[7] && wdata[5] ##1 !cw |=> irq)
        else $error("software set flag gave no request");
    cover property (rd_en && addr == `ADDR_CTRL);
    cover property ($rose(irq));
    cover property ($fell(tx_output_select));
endmodule // uart9_checker
bind half_duplex_nine_bit_uart uart9_checker chk_u (.ref_clk, .rst_n, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .rx_in, .port_level, .tx_out, .tx_output_select, .irq);

// >>> tb/serial_peer.sv
// remote serial device: drives the receive line and captures the transmit line
`timescale 1ns/1ps
module serial_peer (
    // clock
    input wire ref_clk,
    // serial lines
    input wire tx_out,
    input wire tx_output_select,
    output logic rx_line
);
    initial rx_line = 1'b1;
    // start, nine bits lsb first, stop; line rests at the stop level after
    task automatic send(input logic [8:0] c, input int bc);
        logic [10:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rx_line <= f[i];
            repeat (bc) @(posedge ref_clk);
        end
    endtask
    // find a start bit, then sample every bit at its centre
    task automatic grab(input int bc, output logic [8:0] c, output logic ok);
        int n;
        for (n = 0; n < 9000 && !(tx_output_select && !tx_out); n++) @(posedge ref_clk);
        repeat (bc / 2) @(posedge ref_clk);
        ok = (n < 9000) && !tx_out;
        for (int i = 0; i < 9; i++) begin
            repeat (bc) @(posedge ref_clk);
            c[i] = tx_out;
        end
        repeat (bc) @(posedge ref_clk);
        ok = ok && tx_out;
    endtask
endmodule // serial_peer

// >>> tb/testbench.sv
// self-checking bench for the nine-bit uart
`timescale 1ns/1ps
`include "uart9_defines.vh"
module testbench;
    localparam logic [7:0] CR = `ADDR_CTRL;
    localparam logic [7:0] DR = `ADDR_DATA;
    logic ref_clk, rst_n, wr_en, rd_en, port_level, ok;
    logic [7:0] addr, wdata, v;
    logic [8:0] ch;
    wire [7:0] rdata;
    wire rx_in, tx_out, tx_output_select, irq;
    int miscompares, checked;
    int divs [3] = '{208, 256, 416};
    logic [2:0] codes [3] = '{3'd6, 3'd5, 3'd4};
    half_duplex_nine_bit_uart dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_in(rx_in),
        .port_level(port_level), .tx_out(tx_out), .tx_output_select(tx_output_select), .irq(irq));
    serial_peer peer_u (.ref_clk(ref_clk), .tx_out(tx_out),
        .tx_output_select(tx_output_select), .rx_line(rx_in));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle strobes; a spare cycle keeps strobes from being driven twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
        @(posedge ref_clk);
    endtask
    // poll a control bit, bounded
    task automatic poll(input int b);
        int n;
        for (n = 0; n < 4000; n++) begin
            rd(CR, v);
            if (v[b] === 1'b1) break;
        end
        if (n == 4000) begin
            miscompares++;
            final_report();
        end
    endtask
    // time the start bit at one baud code, then finish the character at code 6;
    // the start bit lasts more than seven and at most eight ticks of div/8 cycles
    task automatic baud_probe(input logic [2:0] code, input int div);
        int n;
        wr(CR, {4'h0, code, 1'b0});
        wr(DR, 8'h01);
        @(posedge ref_clk);
        for (n = 0; n < 7000 && tx_out === 1'b0; n++) @(posedge ref_clk);
        check("start bit", {8'h00, n > div / 8 * 7 && n <= div}, 9'h001);
        if (n == 7000) final_report();
        wr(CR, 8'h0c);
        poll(`BIT_TX_EMPTY_FLAG);
    endtask
    initial begin
        {rst_n, wr_en, rd_en, addr, wdata, miscompares, checked} = '0;
        port_level = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(CR, v);
        check("ctrl reset", v, `CTRL_RESET);
        wr(8'hd5, 8'hff);
        rd(8'hd5, v);
        check("unmapped", v, 8'h00);
        port_level <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("idle pin", tx_out, 1'b0);
        port_level <= 1'b1;
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wr(CR, {4'h0, codes[i], 1'b1});
            wr(DR, {5'h14, codes[i]});
            rd(CR, v);
            check("empty cleared", v[6], 1'b0);
            peer_u.grab(divs[i], ch, ok);
            check("frame", ok, 1'b1);
            check("tx char", ch, {1'b1, 5'h14, codes[i]});
            poll(`BIT_TX_EMPTY_FLAG);
            rd(CR, v);
            check("ctrl after tx", v, {4'h4, codes[i], 1'b1});
        end
        wr(CR, 8'h5c);
        repeat (3) @(posedge ref_clk);
        check("tx irq", irq, 1'b1);
        wr(CR, 8'h1c);
        rd(CR, v);
        check("empty cleared", v, 8'h1c);
        check("tx irq off", irq, 1'b0);
        $display("test transmit done");
        wr(CR, 8'h0d);
        peer_u.send(9'h1c3, 208);
        repeat (416) @(posedge ref_clk);
        peer_u.send(9'h05a, 208);
        repeat (64) @(posedge ref_clk);
        rd(DR, v);
        check("rx buffer", v, 8'h5a);
        rd(CR, v);
        check("rx ctrl", v, 8'h8c);
        wr(CR, 8'hac);
        rd(CR, v);
        check("rx enable", v, 8'hac);
        check("rx irq", irq, 1'b1);
        wr(CR, 8'h0c);
        rd(CR, v);
        check("rx cleared", v, 8'h0c);
        check("rx irq off", irq, 1'b0);
        $display("test receive done");
        fork
            peer_u.send(9'h0ff, 208);
            begin
                repeat (600) @(posedge ref_clk);
                wr(DR, 8'h3c);
            end
        join
        poll(`BIT_TX_EMPTY_FLAG);
        rd(CR, v);
        check("abort", v, 8'h4c);
        $display("test abort done");
        baud_probe(3'd0, 6656);
        baud_probe(3'd1, 3328);
        baud_probe(3'd2, 1664);
        baud_probe(3'd3, 832);
        baud_probe(3'd7, 6656);
        $display("test baud codes done");
        final_report();
    end
endmodule // testbench
